/* File: hw/power_save_clock_manager.sv */
/*
 * power-save clock manager: sleep and idle entered by the power-save
 * instruction, doze cpu clock divider, per-module clock gating.
 * assumes the decoder, interrupt controller and watchdog run on i_clk;
 * apb slave with zero wait states.
 */
// Behaviour
// - only power-save instruction enters sleep or idle
// - sleep stops clocks, idle halts cpu only
// - wake on interrupt, reset or watchdog timeout
// - sleep shuts system clock and oscillator
// - fail-safe monitor inactive during sleep
// - rc clock runs in sleep if watchdog on
// - watchdog, if on, cleared just before sleep
// - sleep disables system-clocked peripherals
// - resume on clock source used before sleep
// - watchdog cleared on idle entry
// - idle keeps system clock, peripherals run
// - idle keeps rc clock for watchdog/monitor
// - idle wake restarts cpu at once
// - interrupt during instruction deferred until entry
// - doze slows only the cpu clock
// - doze keeps clock domains synchronized
// - doze enable at bit 11
// - ratio field 14:12, 1:1 to 1:256
// - return-on-interrupt bit 15 restores full speed
// - module disable gates clocks and registers
// - enable clear stops function, keeps registers
// - stop-in-idle bit stops module in idle
`include "pwr_params.svh"
`timescale 1ns/1ns
`default_nettype none

module power_save_clock_manager #(
    parameter int          N_MOD       = 8,
    parameter logic [7:0]  EXT_CLK_MASK = 8'h00
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    // apb slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // instruction decoder
    input  wire logic              i_power_save_instruction_valid,
    input  wire logic              i_power_save_instruction_sel,
    // wake sources and system state
    input  wire logic              i_irq_pending,
    input  wire logic              i_wdt_timeout,
    input  wire logic              i_wdt_enable,
    input  wire logic              i_fail_safe_clock_monitor_enable,
    input  wire logic [2:0]        i_cur_clk_src,
    // clock control
    output logic                   o_cpu_clk_en,
    output logic                   o_cpu_halt,
    output logic                   o_sysclk_run,
    output logic                   o_osc_en,
    output logic                   o_fail_safe_clock_monitor_active,
    output logic                   o_low_power_rc_clock_run,
    output logic                   o_wdt_clear,
    output logic [2:0]             o_resume_clk_src,
    // peripheral control
    output logic [N_MOD-1:0]       o_periph_clk_en,
    output logic [N_MOD-1:0]       o_periph_func_en,
    output logic [N_MOD-1:0]       o_periph_reg_access
);

    ////////////////////////////////////////////////////////////////////
    // registers and state

    pwr_pkg::pwr_state_type  state_r;
    pwr_pkg::pwr_state_type  state_nxt;
    logic                    sel_idle_r;
    logic                    roi_r;
    logic [2:0]              ratio_r;
    logic                    doze_en_r;
    logic [N_MOD-1:0]        mod_dis_r;
    logic [N_MOD-1:0]        mod_en_r;
    logic [N_MOD-1:0]        mod_idl_r;
    logic [`PWR_DIV_W-1:0]   div_cnt_r;
    logic [`PWR_DIV_W-1:0]   div_max;
    logic                    wake;
    logic                    doze_eff;
    logic                    wr_en;
    logic                    setup;
    logic [31:0]             rd_val;
    logic                    rd_hit;

    assign wake     = i_irq_pending | i_wdt_timeout;
    assign doze_eff = doze_en_r & (ratio_r != 3'h0);
    assign setup    = i_psel & ~i_penable;
    assign wr_en    = i_psel & i_penable & o_pready & i_pwrite;
    // power-of-two divisor minus one; top code reaches 1:256
    assign div_max  = (ratio_r == 3'h7) ? {`PWR_DIV_W{1'b1}}
                                        : `PWR_DIV_W'((9'h1 << ratio_r) - 9'h1);

    ////////////////////////////////////////////////////////////////////
    // power state machine

    // next state; irq ignored while entering
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pwr_pkg::ST_RUN: begin
                if (i_power_save_instruction_valid) begin
                    state_nxt = pwr_pkg::ST_ENTER;
                end
            end
            pwr_pkg::ST_ENTER: begin
                if (sel_idle_r) begin
                    state_nxt = pwr_pkg::ST_IDLE;
                end else begin
                    state_nxt = pwr_pkg::ST_SLEEP;
                end
            end
            pwr_pkg::ST_SLEEP, pwr_pkg::ST_IDLE: begin
                if (wake) begin
                    state_nxt = pwr_pkg::ST_RUN;
                end
            end
            default: begin
                state_nxt = pwr_pkg::ST_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= pwr_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // instruction operand capture
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_idle_r <= 1'b0;
        end else if (state_r == pwr_pkg::ST_RUN && i_power_save_instruction_valid) begin
            sel_idle_r <= (i_power_save_instruction_sel == `PWR_SEL_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock source control outputs

    // clocks, oscillator, monitor and rc clock
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cpu_halt    <= 1'b0;
            o_sysclk_run  <= 1'b1;
            o_osc_en      <= 1'b1;
            o_fail_safe_clock_monitor_active <= 1'b0;
            o_low_power_rc_clock_run    <= 1'b0;
        end else begin
            o_cpu_halt    <= (state_nxt != pwr_pkg::ST_RUN);
            o_sysclk_run  <= (state_nxt != pwr_pkg::ST_SLEEP);
            o_osc_en      <= (state_nxt != pwr_pkg::ST_SLEEP);
            o_fail_safe_clock_monitor_active <= i_fail_safe_clock_monitor_enable
                             & (state_nxt != pwr_pkg::ST_SLEEP);
            if (state_nxt == pwr_pkg::ST_SLEEP) begin
                o_low_power_rc_clock_run <= i_wdt_enable;
            end else begin
                o_low_power_rc_clock_run <= i_wdt_enable | i_fail_safe_clock_monitor_enable;
            end
        end
    end

    // watchdog clear pulse on entry
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wdt_clear <= 1'b0;
        end else if (state_nxt == pwr_pkg::ST_ENTER) begin
            o_wdt_clear <= i_wdt_enable
                           | (i_power_save_instruction_sel == `PWR_SEL_IDLE);
        end else begin
            o_wdt_clear <= 1'b0;
        end
    end

    // clock source held across sleep
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_resume_clk_src <= 3'h0;
        end else if (state_r != pwr_pkg::ST_SLEEP) begin
            o_resume_clk_src <= i_cur_clk_src;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // doze divider

    // counter on the system clock keeps both domains aligned
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            div_cnt_r <= '0;
        end else if (!doze_eff || div_cnt_r >= div_max) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + `PWR_DIV_W'(1);
        end
    end

    // cpu clock enable pulse, one in div_max+1 cycles
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cpu_clk_en <= 1'b0;
        end else begin
            o_cpu_clk_en <= (state_nxt == pwr_pkg::ST_RUN)
                            & (!doze_eff || div_cnt_r == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // peripheral control

    // clock gate, function enable, register access
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_periph_clk_en     <= '0;
            o_periph_func_en    <= '0;
            o_periph_reg_access <= '0;
        end else begin
            for (int i = 0; i < N_MOD; i++) begin
                o_periph_clk_en[i] <= ~mod_dis_r[i]
                    & ~(state_nxt == pwr_pkg::ST_SLEEP
                        & ~EXT_CLK_MASK[i])
                    & ~(state_nxt == pwr_pkg::ST_IDLE
                        & mod_idl_r[i]);
                o_periph_func_en[i] <= mod_en_r[i] & ~mod_dis_r[i];
                o_periph_reg_access[i] <= ~mod_dis_r[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave

    // read mux
    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        case (i_paddr)
            `PWR_OFF_CLOCK_DIVIDER_REG: begin
                rd_val[`PWR_ROI_BIT]                  = roi_r;
                rd_val[`PWR_RATIO_HI:`PWR_RATIO_LO] = ratio_r;
                rd_val[`PWR_DOZE_BIT]                 = doze_en_r;
            end
            `PWR_OFF_MOD_DIS: rd_val[N_MOD-1:0] = mod_dis_r;
            `PWR_OFF_MOD_EN:  rd_val[N_MOD-1:0] = mod_en_r;
            `PWR_OFF_MOD_IDL: rd_val[N_MOD-1:0] = mod_idl_r;
            `PWR_OFF_STATUS: begin
                rd_val[1:0] = state_r;
                rd_val[4:2] = o_resume_clk_src;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // answer registered in the setup cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup & ~rd_hit;
            o_prdata  <= (setup & ~i_pwrite) ? rd_val : 32'h0;
        end
    end

    // divider register; interrupt clear of doze wins over a write
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            roi_r     <= 1'b0;
            ratio_r   <= `PWR_RATIO_RST;
            doze_en_r <= 1'b0;
        end else begin
            if (wr_en && i_paddr == `PWR_OFF_CLOCK_DIVIDER_REG) begin
                roi_r     <= i_pwdata[`PWR_ROI_BIT];
                ratio_r   <= i_pwdata[`PWR_RATIO_HI:`PWR_RATIO_LO];
                doze_en_r <= i_pwdata[`PWR_DOZE_BIT];
            end
            if (roi_r && i_irq_pending) begin
                doze_en_r <= 1'b0;
            end
        end
    end

    // module control registers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mod_dis_r <= '0;
            mod_en_r  <= {N_MOD{`PWR_MOD_EN_RST}};
            mod_idl_r <= '0;
        end else if (wr_en) begin
            case (i_paddr)
                `PWR_OFF_MOD_DIS: mod_dis_r <= i_pwdata[N_MOD-1:0];
                `PWR_OFF_MOD_EN:  mod_en_r  <= i_pwdata[N_MOD-1:0];
                `PWR_OFF_MOD_IDL: mod_idl_r <= i_pwdata[N_MOD-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    chk_entry_by_instr: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_ENTER |->
            $past(i_power_save_instruction_valid) && $past(state_r) == pwr_pkg::ST_RUN)
        else $error("low-power entry without instruction");

    chk_sleep_clk_off: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_SLEEP |->
            !o_sysclk_run && !o_osc_en && o_cpu_halt && !o_fail_safe_clock_monitor_active)
        else $error("clock running in sleep");

    chk_idle_clk_on: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_IDLE |-> o_sysclk_run && o_cpu_halt)
        else $error("idle clock state wrong");

    chk_wake_event: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (state_r == pwr_pkg::ST_SLEEP || state_r == pwr_pkg::ST_IDLE)
            && wake |=> state_r == pwr_pkg::ST_RUN && !o_cpu_halt)
        else $error("no wake on event");

    chk_irq_deferred: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_ENTER |=>
            state_r == pwr_pkg::ST_SLEEP || state_r == pwr_pkg::ST_IDLE)
        else $error("entry aborted");

    chk_low_power_rc_clock_sleep: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_SLEEP && $past(i_wdt_enable) |-> o_low_power_rc_clock_run)
        else $error("rc clock off in sleep");

    chk_wdt_clear: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_ENTER && $past(i_wdt_enable) |->
            o_wdt_clear ##1 !o_wdt_clear)
        else $error("watchdog not cleared on entry");

    chk_resume_src: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_SLEEP ##1 state_r == pwr_pkg::ST_SLEEP
            |-> $stable(o_resume_clk_src))
        else $error("clock source lost in sleep");

    chk_doze_cnt: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        doze_eff && $stable(ratio_r) && div_cnt_r == '0 && !i_power_save_instruction_valid
            && state_r == pwr_pkg::ST_RUN |=> o_cpu_clk_en)
        else $error("doze pulse missing");

    chk_roi_clear: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        roi_r && i_irq_pending |=> !doze_en_r)
        else $error("doze kept after interrupt");

    chk_pmd_gate: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (($past(mod_dis_r) & (o_periph_clk_en | o_periph_reg_access))
            == '0))
        else $error("disabled module clocked");

    chk_idle_stop: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        state_r == pwr_pkg::ST_IDLE |->
            ((o_periph_clk_en & $past(mod_idl_r)) == '0))
        else $error("module runs in idle");

endmodule

`default_nettype wire

/* File: hw/pwr_params.svh */
/*
 * offsets, field positions, reset values and counts of the power-save
 * clock manager. assumes a 32-bit apb with byte addresses.
 */
`ifndef PWR_PARAMS_SVH
`define PWR_PARAMS_SVH

// register byte offsets
`define PWR_OFF_CLOCK_DIVIDER_REG   8'h00
`define PWR_OFF_MOD_DIS  8'h04
`define PWR_OFF_MOD_EN   8'h08
`define PWR_OFF_MOD_IDL  8'h0c
`define PWR_OFF_STATUS   8'h10

// clock_divider_reg fields
`define PWR_ROI_BIT      15
`define PWR_RATIO_HI     14
`define PWR_RATIO_LO     12
`define PWR_DOZE_BIT     11

// reset values
`define PWR_RATIO_RST    3'h0
`define PWR_MOD_EN_RST   1'b1

// power-save instruction operand
`define PWR_SEL_SLEEP    1'b0
`define PWR_SEL_IDLE     1'b1

// doze divider counter width (1:256 needs 8 bits)
`define PWR_DIV_W        8

`endif

/* File: hw/pwr_pkg.sv */
/*
 * types of the power-save clock manager.
 * assumes nothing of its surroundings.
 */
package pwr_pkg;
    // operating state of the device
    typedef enum logic [1:0] {
        ST_RUN,
        ST_ENTER,
        ST_SLEEP,
        ST_IDLE
    } pwr_state_type;
endpackage

/* File: sim/pwr_core_model.sv */
/*
 * far-side model: instruction decoder, interrupt controller, watchdog.
 * assumes the manager samples these inputs on rising i_clk edges.
 */
`timescale 1ns/1ns
`default_nettype none

module pwr_core_model (
    // clock
    input  wire logic  i_clk,
    // decoder and wake sources
    output logic       o_power_save_instruction_valid,
    output logic       o_power_save_instruction_sel,
    output logic       o_irq_pending,
    output logic       o_wdt_timeout,
    // system state
    output logic       o_wdt_enable,
    output logic       o_fail_safe_clock_monitor_enable,
    output logic [2:0] o_cur_clk_src
);
    // quiet start
    initial begin
        o_power_save_instruction_valid = 1'b0;
        o_power_save_instruction_sel = 1'b0;
        o_irq_pending = 1'b0;
        o_wdt_timeout = 1'b0;
        o_wdt_enable = 1'b0;
        o_fail_safe_clock_monitor_enable = 1'b0;
        o_cur_clk_src = 3'h0;
    end

    // system configuration levels
    task automatic cfg(input logic w, input logic f, input logic [2:0] s);
        @(posedge i_clk);
        o_wdt_enable <= w;
        o_fail_safe_clock_monitor_enable <= f;
        o_cur_clk_src <= s;
    endtask

    // one-cycle instruction pulse, optional coincident interrupt
    task automatic power_save_instruction(input logic sel, input logic irq);
        @(posedge i_clk);
        o_power_save_instruction_valid <= 1'b1;
        o_power_save_instruction_sel <= sel;
        o_irq_pending <= irq;
        @(posedge i_clk);
        o_power_save_instruction_valid <= 1'b0;
    endtask

    // wake event held until quiet
    task automatic wake(input logic by_wdt);
        @(posedge i_clk);
        if (by_wdt) begin
            o_wdt_timeout <= 1'b1;
        end else begin
            o_irq_pending <= 1'b1;
        end
    endtask

    // drop all wake sources
    task automatic quiet();
        @(posedge i_clk);
        o_irq_pending <= 1'b0;
        o_wdt_timeout <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: sim/tb_power_save_clock_manager.sv */
/*
 * testbench of the power-save clock manager: apb tasks, core model.
 * assumes zero-wait apb and the byte offsets of pwr_params.svh.
 */
`include "pwr_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_power_save_clock_manager;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, pclk, pfun, pacc;
    logic [31:0] pwdata, prdata, rd;
    logic        pv, ps, irq, wto, wen, fen;
    logic        cpu_en, halt, sys_run, osc, fail_safe_clock_monitor, low_power_rc_clock, wclr;
    logic [2:0]  src, rsrc;
    int          error_cnt, n_checks, cnt;

    // clock and apb idle values
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    always #50 clk = ~clk;

    pwr_core_model u_core (.i_clk(clk), .o_power_save_instruction_valid(pv), .o_power_save_instruction_sel(ps),
        .o_irq_pending(irq), .o_wdt_timeout(wto), .o_wdt_enable(wen),
        .o_fail_safe_clock_monitor_enable(fen), .o_cur_clk_src(src));

    power_save_clock_manager #(.EXT_CLK_MASK(8'h80)) u_dut (
        .i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_power_save_instruction_valid(pv),
        .i_power_save_instruction_sel(ps), .i_irq_pending(irq), .i_wdt_timeout(wto),
        .i_wdt_enable(wen), .i_fail_safe_clock_monitor_enable(fen), .i_cur_clk_src(src),
        .o_cpu_clk_en(cpu_en), .o_cpu_halt(halt), .o_sysclk_run(sys_run),
        .o_osc_en(osc), .o_fail_safe_clock_monitor_active(fail_safe_clock_monitor), .o_low_power_rc_clock_run(low_power_rc_clock),
        .o_wdt_clear(wclr), .o_resume_clk_src(rsrc), .o_periph_clk_en(pclk),
        .o_periph_func_en(pfun), .o_periph_reg_access(pacc));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // bounded wait for the cpu to run again
    task automatic wait_run();
        cnt = 0;
        while (halt !== 1'b0 && cnt < 20) begin
            @(posedge clk);
            cnt++;
        end
    endtask

    // verdict
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #2000000;
        error_cnt++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, `PWR_OFF_CLOCK_DIVIDER_REG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PWR_OFF_MOD_EN, 32'h0);
        chk(rd, 32'hff);
        apb(1'b0, 8'h14, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        $display("test reset done");
        // disable and enable bits
        apb(1'b1, `PWR_OFF_MOD_DIS, 32'h03);
        apb(1'b1, `PWR_OFF_MOD_EN, 32'hf7);
        repeat (2) @(posedge clk);
        chk(pclk & 8'h03, 8'h00);
        chk(pacc, 8'hfc);
        chk(pfun, 8'hf4);
        apb(1'b1, `PWR_OFF_MOD_DIS, 32'h0);
        apb(1'b1, `PWR_OFF_MOD_EN, 32'hff);
        $display("test modules done");
        // idle, woken by watchdog
        apb(1'b1, `PWR_OFF_MOD_IDL, 32'h0f);
        u_core.cfg(1'b0, 1'b1, 3'h2);
        u_core.power_save_instruction(`PWR_SEL_IDLE, 1'b0);
        @(posedge clk);
        chk({halt, wclr}, 2'b11);
        @(posedge clk);
        chk({sys_run, low_power_rc_clock, fail_safe_clock_monitor}, 3'b111);
        chk(pclk, 8'hf0);
        u_core.wake(1'b1);
        wait_run();
        @(posedge clk);
        chk({halt, cpu_en}, 2'b01);
        u_core.quiet();
        apb(1'b1, `PWR_OFF_MOD_IDL, 32'h0);
        $display("test idle done");
        // sleep, woken by interrupt
        u_core.cfg(1'b1, 1'b1, 3'h3);
        u_core.power_save_instruction(`PWR_SEL_SLEEP, 1'b0);
        @(posedge clk);
        chk({halt, wclr}, 2'b11);
        @(posedge clk);
        chk({sys_run, osc}, 2'b00);
        chk({fail_safe_clock_monitor, low_power_rc_clock}, 2'b01);
        chk(pclk, 8'h80);
        u_core.cfg(1'b1, 1'b1, 3'h5);
        @(posedge clk);
        chk(rsrc, 3'h3);
        u_core.wake(1'b0);
        wait_run();
        chk(halt, 1'b0);
        u_core.quiet();
        // interrupt coincident with the instruction
        u_core.power_save_instruction(`PWR_SEL_IDLE, 1'b1);
        @(posedge clk);
        chk(halt, 1'b1);
        wait_run();
        chk(halt, 1'b0);
        u_core.quiet();
        // reset wakes from sleep
        u_core.power_save_instruction(`PWR_SEL_SLEEP, 1'b0);
        repeat (2) @(posedge clk);
        chk(sys_run, 1'b0);
        nrst <= 1'b0;
        @(posedge clk);
        chk({halt, sys_run}, 2'b01);
        nrst <= 1'b1;
        $display("test sleep done");
        // doze ratios
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, `PWR_OFF_CLOCK_DIVIDER_REG, 32'h0800 | (32'(k) << 12));
            repeat (4) @(posedge clk);
            cnt = 0;
            repeat (256) begin
                @(posedge clk);
                cnt += int'(cpu_en === 1'b1);
            end
            chk(32'(cnt), (k == 7) ? 32'h1 : 32'(256 >> k));
            chk(pclk, 8'hff);
        end
        apb(1'b1, `PWR_OFF_CLOCK_DIVIDER_REG, 32'hb800);
        u_core.wake(1'b0);
        u_core.quiet();
        apb(1'b0, `PWR_OFF_CLOCK_DIVIDER_REG, 32'h0);
        chk(rd, 32'hb000);
        apb(1'b1, `PWR_OFF_CLOCK_DIVIDER_REG, 32'h3800);
        u_core.wake(1'b0);
        u_core.quiet();
        apb(1'b0, `PWR_OFF_CLOCK_DIVIDER_REG, 32'h0);
        chk(rd, 32'h3800);
        $display("test doze done");
        conclude();
    end
endmodule

`default_nettype wire
